// file: dis_status_port.sv
// Display input status port: read-only byte showing live display timing state.
// Assumes timing inputs come from another clock domain and the host read bus
// is synchronous to CLK; plane select is held by the attribute stage elsewhere.
//
// Contract
// - Bit 7 reads 0 during vertical sync and 1 otherwise.
// - Bit 6 reads 1 when the secondary window is active in the current scan line.
// - Bits 5:4 return a colour output pair chosen by the two-bit plane select.
// - Bit 3 reads 1 during vertical sync, always the inverse of bit 7.
// - Bit 2 reads 1 whenever the secondary window is active.
// - Bit 1 reads 0 while horizontal display enable is asserted, 1 in blanking.
// - Bit 0 reads 1 in any retrace interval and 0 in active display, unlatched.
// - The port decodes at 3BA with the mono map and at 3DA with the colour map.
`timescale 1ns/1ps
module dis_status_port
    import dis_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Host I/O read port
    input  wire logic [15:0] IO_ADDR,
    input  wire logic        IO_RD,
    input  wire logic        COLOR_MAP,
    output logic      [7:0]  IO_RDATA,
    output logic             IO_HIT,
    // Primary display timer
    input  wire logic        VSYNC,
    input  wire logic        HDE,
    input  wire logic        DE,
    // Secondary window controller
    input  wire logic        WIN_LINE,
    input  wire logic        WIN_ACTIVE,
    // Attribute stage
    input  wire logic [7:0]  ATTR_COLOUR,
    input  wire logic [7:0]  ATTR_ALT_COLOUR,
    input  wire logic [1:0]  PLANE_SEL
);

    // ************************************************************
    // Synchronisers for all foreign levels
    // ************************************************************
    localparam int NSYNC = 23;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;

    assign raw_in = {PLANE_SEL, ATTR_ALT_COLOUR, ATTR_COLOUR, WIN_ACTIVE, WIN_LINE, DE, HDE, VSYNC};

    dis_sync #(.WIDTH(NSYNC)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (raw_in),
        .q   (sync_in)
    );

    logic       vsync_s;
    logic       hde_s;
    logic       de_s;
    logic       win_line_s;
    logic       win_act_s;
    logic [7:0] attr_colour_out;
    logic [7:0] attr_alt_out;
    dis_sel_t   sel_s;

    assign vsync_s         = sync_in[0];
    assign hde_s           = sync_in[1];
    assign de_s            = sync_in[2];
    assign win_line_s      = sync_in[3];
    assign win_act_s       = sync_in[4];
    assign attr_colour_out = sync_in[12:5];
    assign attr_alt_out    = sync_in[20:13];
    assign sel_s           = dis_sel_t'(sync_in[22:21]);

    // ************************************************************
    // Status byte assembly
    // ************************************************************
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [1:0] diag;

    // Diagnostic mux picks the colour pair from plane select
    always_comb begin
        case (sel_s)
            DIS_SEL_TWO:   diag = {attr_colour_out[2], attr_alt_out[0]};
            DIS_SEL_FIVE:  diag = {attr_colour_out[5], attr_alt_out[4]};
            DIS_SEL_THREE: diag = {attr_colour_out[3], attr_alt_out[1]};
            DIS_SEL_SEVEN: diag = {attr_colour_out[7], attr_alt_out[6]};
            default:       diag = 2'h0;
        endcase
    end

    // Next status; tracks timing every cycle, no latching on read
    always_comb begin
        nxt_status                 = 8'h00;
        nxt_status[BIT_VSYNC_N]    = ~vsync_s;
        nxt_status[BIT_WIN_LINE]   = win_line_s;
        nxt_status[BIT_DIAG_HI]    = diag[1];
        nxt_status[BIT_DIAG_LO]    = diag[0];
        nxt_status[BIT_VSYNC]      = vsync_s;
        nxt_status[BIT_WIN_ACTIVE] = win_act_s;
        nxt_status[BIT_HDE_N]      = ~hde_s;
        nxt_status[BIT_DE_N]       = ~de_s;
    end

    // Status register; one flop so bits 7 and 3 always flip together
    always_ff @(posedge CLK) begin
        if (RST) begin
            status_ff <= STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ************************************************************
    // Host read decode
    // ************************************************************
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       hit;

    // Address follows the mono/colour map select; other address reads nothing
    always_comb begin
        hit       = IO_RD && (IO_ADDR == (COLOR_MAP ? STATUS_ADDR_COLOR : STATUS_ADDR_MONO));
        nxt_rdata = hit ? status_ff : 8'h00;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign IO_HIT   = hit;
    assign IO_RDATA = rdata_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Sync bits: the status flop lags the synchronised level by exactly one edge
    vsync_low_a: assert property (@(posedge CLK) disable iff (RST)
        $past(vsync_s) |-> !status_ff[BIT_VSYNC_N])
        else $error("bit 7 not low in vsync");
    vsync_high_a: assert property (@(posedge CLK) disable iff (RST)
        !$past(vsync_s) |-> status_ff[BIT_VSYNC_N])
        else $error("bit 7 not high outside vsync");
    vsync_inv_a: assert property (@(posedge CLK) disable iff (RST)
        status_ff[BIT_VSYNC] != status_ff[BIT_VSYNC_N])
        else $error("bits 7 and 3 not inverse");

    // Secondary window bits
    win_line_a: assert property (@(posedge CLK) disable iff (RST)
        status_ff[BIT_WIN_LINE] == $past(win_line_s))
        else $error("bit 6 not window line");
    win_act_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(win_act_s) |=> status_ff[BIT_WIN_ACTIVE])
        else $error("bit 2 not set with window");
    win_level_a: assert property (@(posedge CLK) disable iff (RST)
        status_ff[BIT_WIN_ACTIVE] == $past(win_act_s))
        else $error("bit 2 not window level");

    // Diagnostic pair, one property per select so a swapped leg shows at once
    diag_two_a: assert property (@(posedge CLK) disable iff (RST)
        ($past(sel_s) == DIS_SEL_TWO) |->
        status_ff[5:4] == {$past(attr_colour_out[2]), $past(attr_alt_out[0])})
        else $error("diag pair wrong for select 0");
    diag_five_a: assert property (@(posedge CLK) disable iff (RST)
        ($past(sel_s) == DIS_SEL_FIVE) |->
        status_ff[5:4] == {$past(attr_colour_out[5]), $past(attr_alt_out[4])})
        else $error("diag pair wrong for select 1");
    diag_three_a: assert property (@(posedge CLK) disable iff (RST)
        ($past(sel_s) == DIS_SEL_THREE) |->
        status_ff[5:4] == {$past(attr_colour_out[3]), $past(attr_alt_out[1])})
        else $error("diag pair wrong for select 2");
    diag_mux_a: assert property (@(posedge CLK) disable iff (RST)
        ($past(sel_s) == DIS_SEL_SEVEN) |->
        status_ff[5:4] == {$past(attr_colour_out[7]), $past(attr_alt_out[6])})
        else $error("diag pair wrong for select 3");

    // Display enable bits, both levels of each
    hde_bit_a: assert property (@(posedge CLK) disable iff (RST)
        hde_s |=> !status_ff[BIT_HDE_N])
        else $error("bit 1 not low in display");
    hde_blank_a: assert property (@(posedge CLK) disable iff (RST)
        !hde_s |=> status_ff[BIT_HDE_N])
        else $error("bit 1 not high in blanking");
    de_bit_a: assert property (@(posedge CLK) disable iff (RST)
        !de_s |=> status_ff[BIT_DE_N])
        else $error("bit 0 not high in retrace");
    de_display_a: assert property (@(posedge CLK) disable iff (RST)
        de_s |=> !status_ff[BIT_DE_N])
        else $error("bit 0 not low in display");

    // Address decode and read data timing
    addr_dec_a: assert property (@(posedge CLK) disable iff (RST)
        (IO_RD && COLOR_MAP && IO_ADDR == STATUS_ADDR_MONO) |-> !IO_HIT ##1 IO_RDATA == 8'h00)
        else $error("mono address hit in colour map");
    hit_colour_a: assert property (@(posedge CLK) disable iff (RST)
        (IO_RD && COLOR_MAP && IO_ADDR == STATUS_ADDR_COLOR) |-> IO_HIT)
        else $error("colour address missed");
    hit_mono_a: assert property (@(posedge CLK) disable iff (RST)
        (IO_RD && !COLOR_MAP && IO_ADDR == STATUS_ADDR_MONO) |-> IO_HIT)
        else $error("mono address missed");
    rdata_hit_a: assert property (@(posedge CLK) disable iff (RST)
        IO_HIT |=> IO_RDATA == $past(status_ff))
        else $error("read data not status byte");
    rdata_idle_a: assert property (@(posedge CLK) disable iff (RST)
        !IO_HIT |=> IO_RDATA == 8'h00)
        else $error("read data not zero without hit");

    // A sync level held three edges must have reached the status flop
    sync_lag_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(VSYNC) ##1 VSYNC[*2] |=> status_ff[BIT_VSYNC])
        else $error("vsync not seen after sync delay");

endmodule : dis_status_port

// file: dis_pkg.sv
// Package for the display input status port: I/O addresses, bit positions, reset values.
// Assumes a host I/O bus with 16-bit addresses and 8-bit read data.
package dis_pkg;

    // ************************************************************
    // I/O decode
    // ************************************************************
    localparam logic [15:0] STATUS_ADDR_MONO  = 16'h03BA;
    localparam logic [15:0] STATUS_ADDR_COLOR = 16'h03DA;

    // ************************************************************
    // Bit positions of the status byte
    // ************************************************************
    localparam int BIT_VSYNC_N    = 7;
    localparam int BIT_WIN_LINE   = 6;
    localparam int BIT_DIAG_HI    = 5;
    localparam int BIT_DIAG_LO    = 4;
    localparam int BIT_VSYNC      = 3;
    localparam int BIT_WIN_ACTIVE = 2;
    localparam int BIT_HDE_N      = 1;
    localparam int BIT_DE_N       = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] STATUS_RESET = 8'h83;   // No sync, blanking shown
    localparam logic [1:0] SYNC_RESET   = 2'h0;
    localparam int         SYNC_STAGES  = 2;

    // Plane-select encodings for the diagnostic pair
    typedef enum logic [1:0] {
        DIS_SEL_TWO   = 2'h0,
        DIS_SEL_FIVE  = 2'h1,
        DIS_SEL_THREE = 2'h2,
        DIS_SEL_SEVEN = 2'h3
    } dis_sel_t;

endpackage : dis_pkg

// file: dis_sync.sv
// Two-flop level synchroniser, parameterised in width.
// Assumes the inputs are levels from a foreign timing domain.
`timescale 1ns/1ps
module dis_sync
    import dis_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // ************************************************************
    // Synchroniser stages; the first flop feeds only the second
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : dis_sync

// file: dis_host_model.sv
// Host CPU model for the status port: issues single-byte I/O reads.
// Assumes CLK clocks the port; requests change only at the falling edge.
`timescale 1ns/1ps
module dis_host_model (
    // Clock
    input  wire logic        clk,
    // Host I/O read port
    output logic      [15:0] io_addr,
    output logic             io_rd,
    output logic             color_map,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_hit
);
    // ************************************************************
    // Idle bus values
    // ************************************************************
    initial begin
        io_addr   = 16'h0000;
        io_rd     = 1'b0;
        color_map = 1'b1;
    end

    // One read: held over one rising edge, data taken one cycle later
    task automatic rd(input logic [15:0] a, input logic m, output logic h, output logic [7:0] d);
        @(negedge clk);
        io_rd     = 1'b1;
        io_addr   = a;
        color_map = m;
        #1 h = io_hit;
        @(negedge clk);
        io_rd   = 1'b0;
        io_addr = ~a;   // Stale address never matches by luck
        d       = io_rdata;
    endtask : rd
endmodule : dis_host_model

// file: display_input_status_port_tb_top.sv
// Self-checking bench for the display status port.
// Assumes the host model file is compiled first; timing inputs change at the falling edge.
`timescale 1ns/1ps
module display_input_status_port_tb_top
    import dis_pkg::*;
;
    logic        CLK, RST, COLOR_MAP, IO_RD, IO_HIT, VSYNC, HDE, DE, WIN_LINE, WIN_ACTIVE, h;
    logic [15:0] IO_ADDR;
    logic [7:0]  IO_RDATA, ATTR_COLOUR, ATTR_ALT_COLOUR, d;
    logic [1:0]  PLANE_SEL;
    int          err_total, samples_checked, cycles;

    dis_status_port dis_status_port_inst (.CLK(CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_RD(IO_RD),
        .COLOR_MAP(COLOR_MAP), .IO_RDATA(IO_RDATA), .IO_HIT(IO_HIT), .VSYNC(VSYNC), .HDE(HDE), .DE(DE),
        .WIN_LINE(WIN_LINE), .WIN_ACTIVE(WIN_ACTIVE), .ATTR_COLOUR(ATTR_COLOUR),
        .ATTR_ALT_COLOUR(ATTR_ALT_COLOUR), .PLANE_SEL(PLANE_SEL));
    dis_host_model dis_host_model_inst (.clk(CLK), .io_addr(IO_ADDR), .io_rd(IO_RD),
        .color_map(COLOR_MAP), .io_rdata(IO_RDATA), .io_hit(IO_HIT));

    // ************************************************************
    // Clock and hang guard
    // ************************************************************
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Roughly five times the expected run length
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            summarize();
        end
    end

    // Expected status byte from the present timing inputs
    function automatic logic [7:0] exp_status();
        logic [1:0] dg;
        case (PLANE_SEL)
            2'h0: dg = {ATTR_COLOUR[2], ATTR_ALT_COLOUR[0]};
            2'h1: dg = {ATTR_COLOUR[5], ATTR_ALT_COLOUR[4]};
            2'h2: dg = {ATTR_COLOUR[3], ATTR_ALT_COLOUR[1]};
            default: dg = {ATTR_COLOUR[7], ATTR_ALT_COLOUR[6]};
        endcase
        return {~VSYNC, WIN_LINE, dg, VSYNC, WIN_ACTIVE, ~HDE, ~DE};
    endfunction : exp_status

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk1

    // New random timing state, then long enough for the synchronisers to settle
    task automatic settle(input logic [1:0] sel);
        @(negedge CLK);
        {VSYNC, HDE, DE, WIN_LINE, WIN_ACTIVE} = 5'($urandom);
        ATTR_COLOUR     = 8'($urandom);
        ATTR_ALT_COLOUR = 8'($urandom);
        PLANE_SEL       = sel;
        repeat (5) @(negedge CLK);
    endtask : settle

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(52));
        {VSYNC, HDE, DE, WIN_LINE, WIN_ACTIVE} = 5'h00;
        {ATTR_COLOUR, ATTR_ALT_COLOUR, PLANE_SEL} = 18'h00000;
        RST = 1'b1;
        repeat (8) @(posedge CLK);
        @(negedge CLK) RST = 1'b0;
        // Random live status read through both address maps
        for (int i = 0; i < 200; i++) begin
            settle(i[1:0]);
            dis_host_model_inst.rd(STATUS_ADDR_COLOR, 1'b1, h, d);
            chk1(h, 1'b1, "colour hit");
            chk8(d, exp_status(), "colour status");
            @(negedge CLK);
            chk8(IO_RDATA, 8'h00, "data held too long");
            dis_host_model_inst.rd(STATUS_ADDR_MONO, 1'b0, h, d);
            chk1(h, 1'b1, "mono hit");
            chk8(d, exp_status(), "mono status");
        end
        $display("test random_status done");
        // Wrong map and unmapped addresses are refused
        dis_host_model_inst.rd(STATUS_ADDR_COLOR, 1'b0, h, d);
        chk1(h, 1'b0, "colour addr on mono map");
        chk8(d, 8'h00, "colour addr on mono map");
        dis_host_model_inst.rd(STATUS_ADDR_MONO, 1'b1, h, d);
        chk1(h, 1'b0, "mono addr on colour map");
        chk8(d, 8'h00, "mono addr on colour map");
        dis_host_model_inst.rd(16'h03CA, 1'b1, h, d);
        chk1(h, 1'b0, "unmapped addr");
        chk8(d, 8'h00, "unmapped addr");
        $display("test refusals done");
        // Reset in mid-run: data idles at zero, first read shows the reset byte
        settle(2'h3);
        RST = 1'b1;
        repeat (3) @(negedge CLK);
        chk8(IO_RDATA, 8'h00, "data in reset");
        RST = 1'b0;
        dis_host_model_inst.rd(STATUS_ADDR_COLOR, 1'b1, h, d);
        chk8(d, STATUS_RESET, "first read after reset");
        repeat (4) @(negedge CLK);
        dis_host_model_inst.rd(STATUS_ADDR_COLOR, 1'b1, h, d);
        chk8(d, exp_status(), "status after flush");
        $display("test mid_reset done");
        summarize();
    end
endmodule : display_input_status_port_tb_top
